//--- common/pch_pkg.sv
// package: offsets, fields, reset values and constants of the pci configuration header block
package pch_pkg;
  // -----------------------------------------------------------------
  // register offsets (byte addresses)
  // -----------------------------------------------------------------
  localparam logic [7:0] CLASS_REVISION_OFS      = 8'h08;
  localparam logic [7:0] COMMAND_STATUS_OFS      = 8'h04;
  localparam logic [7:0] SELFTEST_HDR_LAT_OFS    = 8'h0C;
  // -----------------------------------------------------------------
  // field positions, command/status low half
  // -----------------------------------------------------------------
  localparam int IO_EN_BIT         = 0;
  localparam int MEM_EN_BIT        = 1;
  localparam int BUS_MASTER_BIT    = 2;
  localparam int SPECIAL_CYCLE_BIT = 3;
  localparam int WRITE_INVAL_BIT   = 4;
  localparam int PALETTE_BIT       = 5;
  localparam int PARITY_RESP_BIT   = 6;
  localparam int WAIT_CYCLE_BIT    = 7;
  localparam int SYSTEM_ERR_BIT    = 8;
  // -----------------------------------------------------------------
  // class word contents
  // -----------------------------------------------------------------
  localparam logic [7:0] BASE_CLASS_CODE  = 8'h06;
  localparam logic [7:0] SUB_CLASS_CODE   = 8'h80;
  localparam logic [7:0] INTERFACE_CODE   = 8'h00;
  // arbitrary neutral revision value
  localparam logic [7:0] REVISION_DEFAULT = 8'h01;
  // -----------------------------------------------------------------
  // latency timer
  // -----------------------------------------------------------------
  localparam int         LAT_LSB       = 11;
  localparam int         LAT_MSB       = 15;
  localparam logic [4:0] LAT_RESET     = 5'h00;
  localparam logic [7:0] LAT_GRANULE   = 8'h08;
  // -----------------------------------------------------------------
  // power-on strap positions and values
  // -----------------------------------------------------------------
  localparam int         STRAP_BM_BIT  = 14;
  localparam logic [1:0] STRAP_TGT_VAL = 2'h2;
  // -----------------------------------------------------------------
  // pci commands
  // -----------------------------------------------------------------
  localparam logic [3:0] CMD_SPECIAL   = 4'h1;
  localparam logic [3:0] CMD_IO_RD     = 4'h2;
  localparam logic [3:0] CMD_IO_WR     = 4'h3;
  localparam logic [3:0] CMD_MEM_RD    = 4'h6;
  localparam logic [3:0] CMD_MEM_WR    = 4'h7;
  localparam logic [3:0] CMD_MEM_RDM   = 4'hC;
  localparam logic [3:0] CMD_MEM_RDL   = 4'hE;
  localparam logic [3:0] CMD_MEM_WRI   = 4'hF;
endpackage

//--- rtl/pch_latency_timer.sv
// latency timer of the pci master: loads on frame start, counts down, flags expiry
module pch_latency_timer
  import pch_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       active,
  input  wire logic [7:0] load_value,
  output logic            expired
);
  logic [7:0] count;

  // ---------------------------------------------------------------
  // down counter
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count <= 8'h00;
    end else if (start) begin
      count <= load_value;
    end else if (active && count != 8'h00) begin
      count <= count - 8'h01;
    end
  end

  // a zero load counts as already expired, as a master with no slice must yield at once
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      expired <= 1'b0;
    end else if (start) begin
      expired <= (load_value == 8'h00);
    end else if (active && count <= 8'h01) begin
      expired <= 1'b1;
    end else if (!active) begin
      expired <= 1'b0;
    end
  end
endmodule

//--- rtl/pch_config_regs.sv
// pci configuration header registers: command bits, class word, latency timer and their effects
//
// Behaviour
// - wait-cycle bit reads zero, no stepping
// - parity response bit read/write, gates perr
// - serr address parity needs both enables
// - parity always generated on driven cycles
// - palette snoop reads zero, not writable
// - write-invalidate reads zero, never issued
// - special-cycle reads zero, never claimed
// - bus master bit gates vme slave acceptance
// - clearing bus master still drains fifo
// - refuse bad-parity address when both set
// - class word fixed, revision read-only
// - self-test fields read zero
// - multifunction and layout read zero
// - latency timer bits 7:3 writable only
// - expired timer without grant drops frame
// - system error bit read/write, gates serr
module pch_config_regs
  import pch_pkg::*;
#(
  parameter logic [7:0] REVISION = pch_pkg::REVISION_DEFAULT
)
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        power_on,
  input  wire logic [14:12] vme_strap,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rvalid,
  input  wire logic        addr_phase,
  input  wire logic [3:0]  addr_cmd,
  input  wire logic        addr_parity_err,
  input  wire logic        data_parity_err,
  input  wire logic        drive_cycle,
  input  wire logic [35:0] drive_ad_cbe,
  output logic             par_out,
  output logic             perr_n,
  output logic             serr_n,
  output logic             target_claim,
  input  wire logic        mst_req_cmd_valid,
  input  wire logic [3:0]  mst_req_cmd,
  output logic      [3:0]  mst_cmd,
  input  wire logic        mst_start,
  input  wire logic        mst_frame_asserted,
  input  wire logic        irdy_asserted,
  input  wire logic        trdy_asserted,
  input  wire logic        gnt_asserted,
  output logic             frame_release,
  input  wire logic        vme_cycle_req,
  output logic             vme_cycle_accept,
  input  wire logic        fifo_push_req,
  input  wire logic        fifo_not_empty,
  output logic             fifo_push_allow,
  output logic             fifo_drain_allow
);
  logic       parity_response_en;
  logic       system_error_en;
  logic       bus_master_en;
  logic       target_memory_en;
  logic       target_io_en;
  logic       strap_bm;
  logic       strap_tgt;
  logic [4:0] latency_timer;
  logic       lat_expired;
  logic [7:0] lat_load;
  logic [15:0] command_low;
  logic [31:0] selftest_header_latency_word;
  logic [31:0] class_revision_word;
  logic        is_mem_cmd;
  logic        is_io_cmd;
  logic        wr_cmd;
  logic        wr_misc;

  assign wr_cmd  = cfg_wr && cfg_addr == COMMAND_STATUS_OFS;
  assign wr_misc = cfg_wr && cfg_addr == SELFTEST_HDR_LAT_OFS;

  // ---------------------------------------------------------------
  // power-on straps
  // ---------------------------------------------------------------
  // captured only during power-on so that later resets reload the same value
  always_ff @(posedge mclk) begin
    if (power_on) begin
      strap_bm <= vme_strap[STRAP_BM_BIT];
    end
  end

  // memory and io enables share one strap decode, so both always come up alike
  always_ff @(posedge mclk) begin
    if (power_on) begin
      strap_tgt <= (vme_strap[13:12] == STRAP_TGT_VAL);
    end
  end

  // ---------------------------------------------------------------
  // command bits
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      parity_response_en <= 1'b0;
    end else if (wr_cmd && cfg_be[0]) begin
      parity_response_en <= cfg_wdata[PARITY_RESP_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      system_error_en <= 1'b0;
    end else if (wr_cmd && cfg_be[1]) begin
      system_error_en <= cfg_wdata[SYSTEM_ERR_BIT];
    end
  end

  // a reset during power-on sees the strap directly, since the capture flop is not yet loaded
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bus_master_en <= power_on ? vme_strap[STRAP_BM_BIT] : strap_bm;
    end else if (wr_cmd && cfg_be[0]) begin
      bus_master_en <= cfg_wdata[BUS_MASTER_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      target_memory_en <= power_on ? (vme_strap[13:12] == STRAP_TGT_VAL) : strap_tgt;
    end else if (wr_cmd && cfg_be[0]) begin
      target_memory_en <= cfg_wdata[MEM_EN_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      target_io_en <= power_on ? (vme_strap[13:12] == STRAP_TGT_VAL) : strap_tgt;
    end else if (wr_cmd && cfg_be[0]) begin
      target_io_en <= cfg_wdata[IO_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // latency timer field
  // ---------------------------------------------------------------
  // only bits 7:3 are stored; the low three read zero, fixing an eight-clock granularity
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      latency_timer <= LAT_RESET;
    end else if (wr_misc && cfg_be[1]) begin
      latency_timer <= cfg_wdata[LAT_MSB:LAT_LSB];
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    command_low = 16'h0000;
    command_low[PARITY_RESP_BIT] = parity_response_en;
    command_low[SYSTEM_ERR_BIT]  = system_error_en;
    command_low[BUS_MASTER_BIT]  = bus_master_en;
    command_low[MEM_EN_BIT]      = target_memory_en;
    command_low[IO_EN_BIT]       = target_io_en;
    // wait, palette, invalidate and special-cycle bits stay zero
  end

  // self-test, header and low byte all zero
  assign selftest_header_latency_word = {16'h0000, latency_timer, 3'h0, 8'h00};
  assign class_revision_word = {BASE_CLASS_CODE, SUB_CLASS_CODE, INTERFACE_CODE, REVISION};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
    end
  end

  // unmapped offsets read zero, and writes to them are dropped by the decode above
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_rd) begin
      unique case (cfg_addr)
        COMMAND_STATUS_OFS:   cfg_rdata <= {16'h0000, command_low};
        CLASS_REVISION_OFS:   cfg_rdata <= class_revision_word;
        SELFTEST_HDR_LAT_OFS: cfg_rdata <= selftest_header_latency_word;
        default:              cfg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // parity reporting and target decode
  // ---------------------------------------------------------------
  // parity is even across ad and c/be regardless of the response bit
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      par_out <= 1'b0;
    end else if (drive_cycle) begin
      par_out <= ^drive_ad_cbe;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      perr_n <= 1'b1;
    end else begin
      perr_n <= !(data_parity_err && parity_response_en);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      serr_n <= 1'b1;
    end else begin
      serr_n <= !(addr_phase && addr_parity_err && parity_response_en && system_error_en);
    end
  end

  always_comb begin
    is_mem_cmd = addr_cmd == CMD_MEM_RD || addr_cmd == CMD_MEM_WR || addr_cmd == CMD_MEM_RDM ||
                 addr_cmd == CMD_MEM_RDL || addr_cmd == CMD_MEM_WRI;
    is_io_cmd  = addr_cmd == CMD_IO_RD || addr_cmd == CMD_IO_WR;
  end

  // special cycles fall in neither class and are never claimed; palette addresses get no special path
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      target_claim <= 1'b0;
    end else begin
      target_claim <= addr_phase &&
                      ((is_mem_cmd && target_memory_en) || (is_io_cmd && target_io_en)) &&
                      !(addr_parity_err && parity_response_en && system_error_en);
    end
  end

  // ---------------------------------------------------------------
  // master command and latency timer
  // ---------------------------------------------------------------
  // a requested write-and-invalidate is issued as a plain memory write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mst_cmd <= CMD_MEM_WR;
    end else if (mst_req_cmd_valid) begin
      mst_cmd <= (mst_req_cmd == CMD_MEM_WRI) ? CMD_MEM_WR : mst_req_cmd;
    end
  end

  assign lat_load = {latency_timer, 3'h0};

  pch_latency_timer u_lat (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .start      (mst_start),
    .active     (mst_frame_asserted),
    .load_value (lat_load),
    .expired    (lat_expired)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      frame_release <= 1'b0;
    end else begin
      frame_release <= lat_expired && mst_frame_asserted && irdy_asserted &&
                       trdy_asserted && !gnt_asserted;
    end
  end

  // ---------------------------------------------------------------
  // vme slave gating
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vme_cycle_accept <= 1'b0;
    end else begin
      vme_cycle_accept <= vme_cycle_req && bus_master_en;
    end
  end

  // pushes stop while the bit is clear; draining stays open so posted data is never stranded
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fifo_push_allow <= 1'b0;
    end else begin
      fifo_push_allow <= fifo_push_req && bus_master_en;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fifo_drain_allow <= 1'b0;
    end else begin
      fifo_drain_allow <= fifo_not_empty;
    end
  end
endmodule

//--- tb/pch_config_regs_asserts.sv
// checker: port-level assertions of the configuration header block
module pch_config_regs_asserts
  import pch_pkg::*;
#(
  parameter logic [7:0] REVISION = REVISION_DEFAULT
)
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic        addr_phase,
  input wire logic [3:0]  addr_cmd,
  input wire logic        addr_parity_err,
  input wire logic        data_parity_err,
  input wire logic        drive_cycle,
  input wire logic [35:0] drive_ad_cbe,
  input wire logic        par_out,
  input wire logic        perr_n,
  input wire logic        serr_n,
  input wire logic        target_claim,
  input wire logic [3:0]  mst_cmd,
  input wire logic        mst_frame_asserted,
  input wire logic        gnt_asserted,
  input wire logic        frame_release,
  input wire logic        vme_cycle_req,
  input wire logic        vme_cycle_accept,
  input wire logic        fifo_not_empty,
  input wire logic        fifo_drain_allow
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  wire logic [31:0] class_word = {BASE_CLASS_CODE, SUB_CLASS_CODE, INTERFACE_CODE, REVISION};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  class_word_a: assert property (cfg_rd && cfg_addr == CLASS_REVISION_OFS |=> cfg_rdata == class_word)
    else $error("class word wrong");
  csr_fixed_a: assert property (cfg_rd && cfg_addr == COMMAND_STATUS_OFS |=>
    {cfg_rdata[7], cfg_rdata[5:3]} == 4'h0)
    else $error("fixed command bits not zero");
  misc_fixed_a: assert property (cfg_rd && cfg_addr == SELFTEST_HDR_LAT_OFS |=>
    cfg_rdata[31:16] == 16'h0000 && cfg_rdata[10:0] == 11'h000)
    else $error("self-test or header word not zero");
  parity_gen_a: assert property (drive_cycle |=> par_out == ^$past(drive_ad_cbe))
    else $error("parity wrong");
  no_invalidate_a: assert property (mst_cmd != CMD_MEM_WRI)
    else $error("write-invalidate issued");
  no_special_a: assert property (addr_phase && addr_cmd == CMD_SPECIAL |=> !target_claim)
    else $error("special cycle claimed");
  perr_cause_a: assert property (!perr_n |-> $past(data_parity_err))
    else $error("perr without data parity error");
  serr_cause_a: assert property (!serr_n |-> $past(addr_phase) && $past(addr_parity_err))
    else $error("serr without address parity error");
  frame_drop_a: assert property (frame_release |-> $past(mst_frame_asserted) && !$past(gnt_asserted))
    else $error("frame released while granted");
  vme_gate_a: assert property (vme_cycle_accept |-> $past(vme_cycle_req))
    else $error("vme cycle accepted unasked");
  // past of reset guards the first edge, where the output still shows its reset value
  drain_free_a: assert property ($past(rst_n) |-> fifo_drain_allow == $past(fifo_not_empty))
    else $error("fifo drain not following fill");
endmodule

bind pch_config_regs pch_config_regs_asserts #(.REVISION(REVISION)) u_pch_config_regs_asserts (.*);

//--- tb/pch_host_model.sv
// host model: issues configuration reads and writes
module pch_host_model
(
  input  wire logic        mclk,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rvalid,
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic      [7:0]  cfg_addr,
  output logic      [3:0]  cfg_be,
  output logic      [31:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'hA5;
    cfg_be = 4'h0;
    cfg_wdata = 32'h5A5A_5A5A;
  end
  // released address, byte-enable and data lines show the inverse and strobes drop to zero, so stale values are never mistaken for live ones
  task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge mclk);
    cfg_wr <= wr;
    cfg_rd <= !wr;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    cfg_addr <= ~a;
    cfg_be <= ~be;
    cfg_wdata <= ~d;
    q = 32'h0;
    if (!wr) begin
      @(posedge mclk);
      q = (cfg_rvalid === 1'b1) ? cfg_rdata : 32'hDEAD_BEEF;
    end
  endtask
endmodule

//--- tb/pch_config_regs_tb_top.sv
// testbench: configuration header block against a behavioural model
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module pch_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pch_pkg::*;
  logic         mclk = 1'b0, rst_n = 1'b0, power_on = 1'b1, addr_phase = 1'b0, addr_parity_err = 1'b0;
  logic         data_parity_err = 1'b0, drive_cycle = 1'b0, mst_req_cmd_valid = 1'b0, mst_start = 1'b0;
  logic         mst_frame_asserted = 1'b0, irdy_asserted = 1'b0, trdy_asserted = 1'b0, gnt_asserted = 1'b0;
  logic         vme_cycle_req = 1'b0, fifo_push_req = 1'b0, fifo_not_empty = 1'b0;
  logic [14:12] vme_strap = 3'h0;
  logic [3:0]   addr_cmd = 4'h0, mst_req_cmd = 4'h0, cfg_be, mst_cmd;
  logic [35:0]  drive_ad_cbe = 36'h0;
  logic [7:0]   cfg_addr;
  logic [31:0]  cfg_wdata, cfg_rdata;
  logic         cfg_wr, cfg_rd, cfg_rvalid, par_out, perr_n, serr_n, target_claim, frame_release;
  logic         vme_cycle_accept, fifo_push_allow, fifo_drain_allow;
  logic [31:0]  csr_tab [6] = '{32'h0, 32'h147, 32'h40, 32'h100, 32'h3, 32'h4};
  logic [3:0]   cmd_tab [8] = '{CMD_MEM_RD, CMD_MEM_WRI, CMD_IO_WR, CMD_IO_RD,
                                CMD_SPECIAL, CMD_MEM_RDL, CMD_MEM_RDM, CMD_MEM_WR};
  int           exp_csr, exp_lat, mismatches, checked, cycles;
  integer       seed = 90412;
  pch_config_regs u_pch_config_regs (.*);
  pch_host_model u_pch_host_model (.*);
  // ---------------------------------------------------------------
  // clock, timeout, model and tasks
  // ---------------------------------------------------------------
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] s, input logic pwr);
    @(posedge mclk);
    rst_n <= 1'b0;
    power_on <= pwr;
    vme_strap <= s;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    power_on <= 1'b0;
    exp_csr = pwr ? {s[2], s[1:0] == 2'h2, s[1:0] == 2'h2} : exp_csr & 7;
    exp_lat = 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    u_pch_host_model.access(1'b1, a, be, d, q);
    if (a == COMMAND_STATUS_OFS && be[0]) exp_csr[7:0] = d[7:0] & 8'h47;
    if (a == COMMAND_STATUS_OFS && be[1]) exp_csr[8] = d[8];
    if (a == SELFTEST_HDR_LAT_OFS && be[1]) exp_lat = d[15:11];
  endtask
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      COMMAND_STATUS_OFS:   return {23'h0, exp_csr[8:0]};
      CLASS_REVISION_OFS:   return {BASE_CLASS_CODE, SUB_CLASS_CODE, INTERFACE_CODE, REVISION_DEFAULT};
      SELFTEST_HDR_LAT_OFS: return {16'h0, exp_lat[4:0], 11'h0};
      default:              return 32'h0;
    endcase
  endfunction
  task automatic rd_chk(input logic [7:0] a);
    logic [31:0] q;
    u_pch_host_model.access(1'b0, a, 4'hF, 32'h0, q);
    `CHK(q, exp_rd(a));
  endtask
  task automatic pulse(input logic [3:0] cmd, input logic ape);
    @(posedge mclk);
    {addr_phase, addr_parity_err, data_parity_err} <= {1'b1, ape, !ape};
    {vme_cycle_req, fifo_push_req, fifo_not_empty} <= 3'h7;
    addr_cmd <= cmd;
    @(posedge mclk);
    {addr_phase, addr_parity_err, data_parity_err, vme_cycle_req, fifo_push_req, fifo_not_empty} <= 6'h00;
    addr_cmd <= ~cmd;
    // responses launched at the edge above are read half a cycle later, clear of any edge
    @(negedge mclk);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [63:0] r;
    logic [3:0]  cmd;
    logic        ape, claim;
    r = {$random(seed), $random(seed)};
    do_reset(r[2:0], 1'b1);
    rd_chk(COMMAND_STATUS_OFS);
    do_reset(~r[2:0], 1'b0);
    rd_chk(COMMAND_STATUS_OFS);
    $display("test reset done");
    wr(CLASS_REVISION_OFS, 4'hF, 32'hFFFF_FFFF);
    wr(8'h10, 4'hF, 32'hFFFF_FFFF);
    rd_chk(CLASS_REVISION_OFS);
    rd_chk(8'h10);
    rd_chk(8'h00);
    repeat (8) begin
      r = {$random(seed), $random(seed)};
      wr(COMMAND_STATUS_OFS, r[35:32], r[31:0]);
      wr(SELFTEST_HDR_LAT_OFS, r[39:36], ~r[31:0]);
      rd_chk(COMMAND_STATUS_OFS);
      rd_chk(SELFTEST_HDR_LAT_OFS);
    end
    $display("test registers done");
    foreach (csr_tab[i]) begin
      wr(COMMAND_STATUS_OFS, 4'h3, csr_tab[i]);
      for (int k = 0; k < 8; k++) begin
        cmd = cmd_tab[k];
        ape = k[0];
        pulse(cmd, ape);
        claim = !(ape && exp_csr[6] && exp_csr[8]) &&
                ((cmd inside {CMD_IO_RD, CMD_IO_WR}) ? exp_csr[0] : (cmd != CMD_SPECIAL && exp_csr[1]));
        `CHK(perr_n, !(!ape && exp_csr[6]));
        `CHK(serr_n, !(ape && exp_csr[6] && exp_csr[8]));
        `CHK(target_claim, claim);
        `CHK({vme_cycle_accept, fifo_push_allow, fifo_drain_allow}, {exp_csr[2], exp_csr[2], 1'b1});
      end
    end
    $display("test events done");
    for (int c = 0; c < 16; c++) begin
      r = {$random(seed), $random(seed)};
      @(posedge mclk);
      {mst_req_cmd_valid, drive_cycle, mst_req_cmd, drive_ad_cbe} <= {2'b11, c[3:0], r[35:0]};
      @(posedge mclk);
      {mst_req_cmd_valid, drive_cycle, drive_ad_cbe} <= {2'b00, ~r[35:0]};
      @(posedge mclk);
      `CHK(mst_cmd, c == 15 ? CMD_MEM_WR : c[3:0]);
      `CHK(par_out, ^r[35:0]);
    end
    wr(SELFTEST_HDR_LAT_OFS, 4'h2, 32'h0000_0800);
    for (int g = 1; g >= 0; g--) begin
      @(posedge mclk);
      {mst_start, mst_frame_asserted, irdy_asserted, trdy_asserted, gnt_asserted} <= {4'hF, g[0]};
      @(posedge mclk);
      mst_start <= 1'b0;
      ape = 1'b0;
      repeat (16) @(posedge mclk) ape = ape | frame_release;
      `CHK(ape, !g[0]);
      {mst_frame_asserted, irdy_asserted, trdy_asserted} <= 3'h0;
    end
    $display("test master done");
    tally_and_finish();
  end
endmodule
